// ### cie_pkg.sv
// Constants, register map and encodings for the instruction execution core
package cie_pkg;

  // Register byte offsets on the APB slave
  localparam int unsigned PADDR_W      = 8;
  localparam logic [7:0]  OFF_CMD      = 8'h00;
  localparam logic [7:0]  OFF_OPADDR   = 8'h04;
  localparam logic [7:0]  OFF_IMM      = 8'h08;
  localparam logic [7:0]  OFF_ACC      = 8'h0C;
  localparam logic [7:0]  OFF_FLAGS    = 8'h10;
  localparam logic [7:0]  OFF_TPLOW    = 8'h14;
  localparam logic [7:0]  OFF_TPHIGH   = 8'h18;
  localparam logic [7:0]  OFF_THLATCH  = 8'h1C;
  localparam logic [7:0]  OFF_STATUS   = 8'h20;
  localparam logic [7:0]  OFF_CYCLES   = 8'h24;
  localparam logic [7:0]  OFF_DMADDR   = 8'h28;
  localparam logic [7:0]  OFF_DMDATA   = 8'h2C;
  localparam logic [7:0]  OFF_PMADDR   = 8'h30;
  localparam logic [7:0]  OFF_PMDATA   = 8'h34;

  // Command register fields
  localparam int unsigned CMD_W        = 11;
  localparam int unsigned CMD_OP_LSB   = 0;
  localparam int unsigned CMD_OP_W     = 5;
  localparam int unsigned CMD_TOACC    = 5;
  localparam int unsigned CMD_LONG     = 6;
  localparam int unsigned CMD_BIT_LSB  = 8;
  localparam int unsigned CMD_BIT_W    = 3;

  // Flag register bit positions
  localparam int unsigned FLG_W        = 6;
  localparam int unsigned FLG_C        = 0;
  localparam int unsigned FLG_AUX      = 1;
  localparam int unsigned FLG_Z        = 2;
  localparam int unsigned FLG_OVF      = 3;
  localparam int unsigned FLG_SGN      = 4;
  localparam int unsigned FLG_CYZ      = 5;

  // Status register bit positions
  localparam int unsigned STS_BUSY     = 0;
  localparam int unsigned STS_SKIP     = 1;
  localparam int unsigned STS_DISCARD  = 2;

  // Reset values
  localparam logic [7:0]       ACC_RST = 8'h00;
  localparam logic [FLG_W-1:0] FLG_RST = 6'h00;
  localparam logic [7:0]       TBL_RST = 8'h00;

  // Arithmetic constants
  localparam logic [7:0]  DAA_LOW_ADJ  = 8'h06;
  localparam logic [7:0]  DAA_HIGH_ADJ = 8'h60;
  localparam logic [3:0]  BCD_MAX      = 4'h9;
  localparam int unsigned SECTION_W    = 8;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_DUMMY = 2'b11
  } cie_state_e;

  typedef enum logic [4:0] {
    OP_NOP    = 5'h00, OP_SWAP  = 5'h01, OP_SKZ    = 5'h02, OP_SKZA  = 5'h03,
    OP_SZBIT  = 5'h04, OP_TRD   = 5'h05, OP_TRDF   = 5'h06, OP_ITRD  = 5'h07,
    OP_ITRDF  = 5'h08, OP_XOR   = 5'h09, OP_XORI   = 5'h0A, OP_ADC   = 5'h0B,
    OP_ADD    = 5'h0C, OP_AND   = 5'h0D, OP_OR     = 5'h0E, OP_CLR   = 5'h0F,
    OP_CLRBIT = 5'h10, OP_CPL   = 5'h11, OP_DAA    = 5'h12, OP_DEC   = 5'h13,
    OP_INC    = 5'h14, OP_MOVLD = 5'h15, OP_MOVST  = 5'h16, OP_RL    = 5'h17,
    OP_RLC    = 5'h18
  } cie_op_e;

endpackage : cie_pkg

// ### cie_exec_core.sv
// Execution core for a subset of an 8-bit instruction set, with APB register access
//
// Summary of operation
// - Nibble exchange swaps byte halves into memory or accumulator; flags untouched.
// - Byte zero test rewrites byte; zero skips next instruction via dummy cycle.
// - Move-and-test copies byte to accumulator; zero value skips with dummy cycle.
// - Bit test skips next instruction with dummy cycle when selected bit clear.
// - Page table read uses high and low pointers; low to memory, high latched.
// - Final page table read uses low pointer on last program page only.
// - Incrementing table reads bump low pointer first, then read as usual.
// - Exclusive-OR with byte to accumulator or memory, or with immediate to accumulator only; zero flag only.
// - Extended group addresses any data memory section directly.
// - Add with carry updates overflow, zero, aux carry, carry and signed flags.
// - Add without carry stores sum and updates the same five flags.
// - AND to accumulator or memory, changing only the zero flag.
// - OR to accumulator or memory, changing only the zero flag.
// - Clear writes zero to byte or one bit; no flag changes.
// - Complement inverts byte into memory or accumulator; zero flag only.
// - Decimal adjust adds six per nibble, result to memory; only carry may change.
// - Decrement by one into memory or accumulator; zero flag only.
// - Increment by one into memory or accumulator; zero flag only.
// - Move copies byte to accumulator or accumulator to byte; no flags.
// - Rotate left wraps bit seven into bit zero; no flags.
// - Rotate left through carry; old carry to bit zero, bit seven to carry.
`timescale 1ns/1ns
`default_nettype none

module cie_exec_core
  import cie_pkg::*;
#(
  parameter int unsigned DM_AW = 10,   // Data memory address width (four sections)
  parameter int unsigned PM_AW = 12    // Program memory word address width, above 8
) (
  input  wire logic               clock,    // Core clock, 25 MHz
  input  wire logic               arst_n,   // Asynchronous reset, active low
  input  wire logic               psel,     // APB select
  input  wire logic               penable,  // APB access phase
  input  wire logic               pwrite,   // APB direction, high for write
  input  wire logic [PADDR_W-1:0] paddr,    // APB byte address
  input  wire logic [31:0]        pwdata,   // APB write data
  input  wire logic [3:0]         pstrb,    // APB byte strobes
  output logic      [31:0]        prdata,   // APB read data, registered
  output logic                    pready,   // APB ready
  output logic                    pslverr   // APB error on access phase
);
  typedef struct packed {
    cie_state_e       st;
    logic [CMD_W-1:0] cmd;
    logic [DM_AW-1:0] opAddr;
    logic [7:0]       imm;
    logic [7:0]       acc;
    logic [FLG_W-1:0] flg;
    logic [7:0]       tpLow;
    logic [7:0]       tpHigh;
    logic [7:0]       thLatch;
    logic             skipPend;
    logic             discarded;
    logic [15:0]      cycles;
    logic [DM_AW-1:0] dmAddr;
    logic [PM_AW-1:0] pmAddr;
    logic [31:0]      rdata;
    logic             err;
  } cie_regs_s;
  cie_regs_s r_q;
  cie_regs_s r_d;
  logic [7:0]  dmem [2**DM_AW];
  logic [15:0] pmem [2**PM_AW];
  logic [7:0]       opnd;
  logic [15:0]      pword;
  logic [PM_AW-1:0] pmRdAddr;
  logic [7:0]       ptrLow;
  logic [DM_AW-1:0] effAddr;
  logic             dmWe;
  logic [DM_AW-1:0] dmWa;
  logic [7:0]       dmWd;
  logic             pmWe;
  logic [15:0]      pmWd;
  logic             execCyc;
  logic             wrMem;
  logic [7:0]       res;
  cie_op_e          op;
  logic             toAcc;
  logic [2:0]       bitSel;
  function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return m;
  endfunction : strbMerge
  function automatic logic isTableOp(input cie_op_e o);
    return (o == OP_TRD) || (o == OP_TRDF) || (o == OP_ITRD) || (o == OP_ITRDF);
  endfunction : isTableOp
  assign op      = cie_op_e'(r_q.cmd[CMD_OP_LSB +: CMD_OP_W]);
  assign toAcc   = r_q.cmd[CMD_TOACC];
  assign bitSel  = r_q.cmd[CMD_BIT_LSB +: CMD_BIT_W];
  assign execCyc = (r_q.st == ST_EXEC);
  // Short forms only see the first section; the long form reaches them all
  assign effAddr = r_q.cmd[CMD_LONG] ? r_q.opAddr
                 : {{(DM_AW-SECTION_W){1'b0}}, r_q.opAddr[SECTION_W-1:0]};
  assign opnd    = dmem[effAddr];
  // Pre-increment feeds the same read path as the plain table reads
  assign ptrLow   = ((op == OP_ITRD) || (op == OP_ITRDF)) ? r_q.tpLow + 8'h01
                  : r_q.tpLow;
  assign pmRdAddr = ((op == OP_TRDF) || (op == OP_ITRDF))
                  ? {{(PM_AW-8){1'b1}}, ptrLow}
                  : PM_AW'({r_q.tpHigh, ptrLow});
  assign pword    = pmem[pmRdAddr];
  assign pready  = 1'b1;
  assign pslverr = r_q.err & psel & penable;
  assign prdata  = r_q.rdata;
  always_comb begin
    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic        cin;
    logic        wrAcc;
    logic        zUpd;
    logic        skip;
    logic        mapped;
    logic [31:0] rd;
    logic [7:0]  adj;
    r_d   = r_q;
    sum9  = 9'h000;
    sum5  = 5'h00;
    cin   = 1'b0;
    wrAcc = 1'b0;
    zUpd  = 1'b0;
    skip  = 1'b0;
    wrMem = 1'b0;
    res   = opnd;
    adj   = 8'h00;
    rd    = 32'h0000_0000;
    mapped = 1'b1;
    case (r_q.st)
      ST_EXEC: begin
        r_d.cycles = r_q.cycles + 16'h0001;
        r_d.st     = ST_IDLE;
        if (r_q.skipPend) begin
          // The fetched instruction dies here and leaves no architectural trace
          r_d.skipPend  = 1'b0;
          r_d.discarded = 1'b1;
        end else begin
          r_d.discarded = 1'b0;
          case (op)
            OP_SWAP: begin
              res = {opnd[3:0], opnd[7:4]};
              wrAcc = toAcc;
              wrMem = !toAcc;
            end
            OP_SKZ: begin
              wrMem = 1'b1;
              skip  = (opnd == 8'h00);
            end
            OP_SKZA: begin
              wrAcc = 1'b1;
              skip  = (opnd == 8'h00);
            end
            OP_SZBIT: skip = !opnd[bitSel];
            OP_TRD, OP_TRDF, OP_ITRD, OP_ITRDF: begin
              res = pword[7:0];
              wrMem = 1'b1;
              r_d.thLatch = pword[15:8];
              r_d.tpLow   = ptrLow;
            end
            OP_XOR, OP_XORI: begin
              res  = r_q.acc ^ ((op == OP_XORI) ? r_q.imm : opnd);
              zUpd = 1'b1;
              wrAcc = toAcc || (op == OP_XORI);
              wrMem = !toAcc && (op == OP_XOR);
            end
            OP_ADC, OP_ADD: begin
              cin  = (op == OP_ADC) ? r_q.flg[FLG_C] : 1'b0;
              sum9 = {1'b0, r_q.acc} + {1'b0, opnd} + {8'h00, cin};
              sum5 = {1'b0, r_q.acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
              res  = sum9[7:0];
              zUpd = 1'b1;
              wrAcc = toAcc;
              wrMem = !toAcc;
              r_d.flg[FLG_C]  = sum9[8];
              r_d.flg[FLG_AUX] = sum5[4];
              r_d.flg[FLG_OVF] = (r_q.acc[7] == opnd[7]) && (sum9[7] != r_q.acc[7]);
              r_d.flg[FLG_SGN] = ((r_q.acc[7] == opnd[7]) && (sum9[7] != r_q.acc[7]))
                                ^ sum9[7];
            end
            OP_AND, OP_OR: begin
              res  = (op == OP_AND) ? (r_q.acc & opnd) : (r_q.acc | opnd);
              zUpd = 1'b1;
              wrAcc = toAcc;
              wrMem = !toAcc;
            end
            OP_CLR: begin
              res   = 8'h00;
              wrMem = 1'b1;
            end
            OP_CLRBIT: begin
              res   = opnd & ~(8'h01 << bitSel);
              wrMem = 1'b1;
            end
            OP_CPL: begin
              res  = ~opnd;
              zUpd = 1'b1;
              wrAcc = toAcc;
              wrMem = !toAcc;
            end
            OP_DAA: begin
              if ((r_q.acc[3:0] > BCD_MAX) || r_q.flg[FLG_AUX]) begin
                adj = adj | DAA_LOW_ADJ;
              end
              if ((r_q.acc[7:4] > BCD_MAX) || r_q.flg[FLG_C]) begin
                adj = adj | DAA_HIGH_ADJ;
              end
              sum9  = {1'b0, r_q.acc} + {1'b0, adj};
              res   = sum9[7:0];
              wrMem = 1'b1;
              // Carry is only ever raised, so a multi-byte decimal chain keeps it
              r_d.flg[FLG_C] = r_q.flg[FLG_C] | sum9[8];
            end
            OP_DEC, OP_INC: begin
              res  = (op == OP_INC) ? opnd + 8'h01 : opnd - 8'h01;
              zUpd = 1'b1;
              wrAcc = toAcc;
              wrMem = !toAcc;
            end
            OP_MOVLD: wrAcc = 1'b1;
            OP_MOVST: begin
              res   = r_q.acc;
              wrMem = 1'b1;
            end
            OP_RL: begin
              res  = {opnd[6:0], opnd[7]};
              wrAcc = toAcc;
              wrMem = !toAcc;
            end
            OP_RLC: begin
              res  = {opnd[6:0], r_q.flg[FLG_C]};
              r_d.flg[FLG_C] = opnd[7];
              wrAcc = toAcc;
              wrMem = !toAcc;
            end
            default: ;
          endcase
          if (wrAcc) begin
            r_d.acc = res;
          end
          if (zUpd) begin
            r_d.flg[FLG_Z] = (res == 8'h00);
          end
          if (skip) begin
            r_d.st       = ST_DUMMY;
            r_d.skipPend = 1'b1;
          end
        end
      end
      ST_DUMMY: begin
        r_d.cycles = r_q.cycles + 16'h0001;
        r_d.st     = ST_IDLE;
      end
      ST_IDLE: ;
      default: r_d.st = ST_IDLE;
    endcase
    // Read data and error are fixed in the setup phase so the access phase sees flops
    case (paddr)
      OFF_CMD:     rd = 32'(r_q.cmd);
      OFF_OPADDR:  rd = 32'(r_q.opAddr);
      OFF_IMM:     rd = 32'(r_q.imm);
      OFF_ACC:     rd = 32'(r_q.acc);
      OFF_FLAGS:   rd = 32'(r_q.flg);
      OFF_TPLOW:   rd = 32'(r_q.tpLow);
      OFF_TPHIGH:  rd = 32'(r_q.tpHigh);
      OFF_THLATCH: rd = 32'(r_q.thLatch);
      OFF_STATUS:  rd = 32'({r_q.discarded, r_q.skipPend, (r_q.st != ST_IDLE)});
      OFF_CYCLES:  rd = 32'(r_q.cycles);
      OFF_DMADDR:  rd = 32'(r_q.dmAddr);
      OFF_DMDATA:  rd = 32'(dmem[r_q.dmAddr]);
      OFF_PMADDR:  rd = 32'(r_q.pmAddr);
      OFF_PMDATA:  rd = 32'(pmem[r_q.pmAddr]);
      default:     mapped = 1'b0;
    endcase
    if (psel && !penable) begin
      r_d.rdata = rd;
      // Writes while executing are refused rather than stalled to keep pready simple
      r_d.err   = !mapped || (pwrite && (r_q.st != ST_IDLE));
    end
    if (psel && penable && pwrite && !r_q.err) begin
      case (paddr)
        OFF_CMD: begin
          r_d.cmd = CMD_W'(strbMerge(32'(r_q.cmd), pwdata, pstrb));
          r_d.st  = ST_EXEC;
        end
        OFF_OPADDR: r_d.opAddr = DM_AW'(strbMerge(32'(r_q.opAddr), pwdata, pstrb));
        OFF_IMM:    r_d.imm    = 8'(strbMerge(32'(r_q.imm), pwdata, pstrb));
        OFF_ACC:    r_d.acc    = 8'(strbMerge(32'(r_q.acc), pwdata, pstrb));
        OFF_FLAGS:  r_d.flg    = FLG_W'(strbMerge(32'(r_q.flg), pwdata, pstrb));
        OFF_TPLOW:  r_d.tpLow  = 8'(strbMerge(32'(r_q.tpLow), pwdata, pstrb));
        OFF_TPHIGH: r_d.tpHigh = 8'(strbMerge(32'(r_q.tpHigh), pwdata, pstrb));
        OFF_DMADDR: r_d.dmAddr = DM_AW'(strbMerge(32'(r_q.dmAddr), pwdata, pstrb));
        OFF_PMADDR: r_d.pmAddr = PM_AW'(strbMerge(32'(r_q.pmAddr), pwdata, pstrb));
        default: ;
      endcase
    end
  end
  // Memory write ports; execution and APB never write in the same cycle
  always_comb begin
    dmWe = 1'b0;
    dmWa = effAddr;
    dmWd = res;
    pmWe = 1'b0;
    pmWd = pmem[r_q.pmAddr];
    if (execCyc && !r_q.skipPend && wrMem) begin
      dmWe = 1'b1;
    end else if (psel && penable && pwrite && !r_q.err && (paddr == OFF_DMDATA) && pstrb[0]) begin
      dmWe = 1'b1;
      dmWa = r_q.dmAddr;
      dmWd = pwdata[7:0];
    end
    if (psel && penable && pwrite && !r_q.err && (paddr == OFF_PMDATA)) begin
      pmWe = 1'b1;
      pmWd = 16'(strbMerge(32'(pmem[r_q.pmAddr]), pwdata, pstrb));
    end
  end
  always_ff @(posedge clock) begin
    if (dmWe) begin
      dmem[dmWa] <= dmWd;
    end
    if (pmWe) begin
      pmem[r_q.pmAddr] <= pmWd;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      r_q <= '{st: ST_IDLE, cmd: '0, opAddr: '0, imm: 8'h00, acc: ACC_RST, flg: FLG_RST,
               tpLow: TBL_RST, tpHigh: TBL_RST, thLatch: TBL_RST, skipPend: 1'b0,
               discarded: 1'b0, cycles: 16'h0000, dmAddr: '0, pmAddr: '0,
               rdata: 32'h0000_0000, err: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end
  // Previous-cycle copies used only by the checks below
  logic [7:0]  opndH;
  logic [7:0]  accH;
  logic [15:0] pwordH;
  logic        liveExec;
  assign liveExec = execCyc && !r_q.skipPend;
  always_ff @(posedge clock) begin
    opndH  <= opnd;
    accH   <= r_q.acc;
    pwordH <= pword;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_swap_to_acc: assert property (liveExec && op == OP_SWAP && toAcc |=>
    r_q.acc == {opndH[3:0], opndH[7:4]} && r_q.flg == $past(r_q.flg))
    else $error("nibble exchange into accumulator wrong");
  a_zero_skip: assert property (liveExec && op == OP_SKZ && opnd == 8'h00 |=>
    r_q.st == ST_DUMMY ##1 r_q.st == ST_IDLE && r_q.skipPend)
    else $error("zero test did not insert one dummy cycle");
  a_move_test: assert property (liveExec && op == OP_SKZA |=>
    r_q.acc == opndH && r_q.skipPend == (opndH == 8'h00))
    else $error("move and test result or skip wrong");
  a_bit_noskip: assert property (liveExec && op == OP_SZBIT && opnd[bitSel] |=>
    r_q.st == ST_IDLE && !r_q.skipPend)
    else $error("bit test skipped on set bit");
  a_table_high: assert property (liveExec && isTableOp(op) |=>
    r_q.thLatch == pwordH[15:8])
    else $error("table high latch not loaded");
  a_table_inc: assert property (liveExec && (op == OP_ITRD || op == OP_ITRDF) |=>
    r_q.tpLow == $past(r_q.tpLow) + 8'h01)
    else $error("table pointer low not incremented");
  a_xor_zero: assert property (liveExec && op == OP_XORI && r_q.acc == r_q.imm |=>
    r_q.flg[FLG_Z] && r_q.acc == 8'h00)
    else $error("xor zero flag wrong");
  a_add_sum: assert property (liveExec && op == OP_ADD && toAcc |=>
    {r_q.flg[FLG_C], r_q.acc} == {1'b0, accH} + {1'b0, opndH})
    else $error("add result or carry wrong");
  a_daa_flags: assert property (liveExec && op == OP_DAA |=>
    r_q.flg[FLG_W-1:FLG_AUX] == $past(r_q.flg[FLG_W-1:FLG_AUX]) && r_q.acc == accH)
    else $error("decimal adjust touched more than carry");
  a_rlc_carry: assert property (liveExec && op == OP_RLC |=>
    r_q.flg[FLG_C] == opndH[7])
    else $error("rotate through carry lost bit seven");
  a_skip_discard: assert property (execCyc && r_q.skipPend |=>
    r_q.acc == accH && r_q.flg == $past(r_q.flg) && !r_q.skipPend && r_q.discarded)
    else $error("skipped instruction changed state");
  c_skip_taken: cover property (liveExec && op == OP_SKZ && opnd == 8'h00);
  c_discard:    cover property (execCyc && r_q.skipPend);
  c_add_carry:  cover property (liveExec && op == OP_ADC && r_q.flg[FLG_C]);
  c_apb_error:  cover property (pslverr);
endmodule : cie_exec_core

`default_nettype wire

// ### test_cie_exec_core.sv
// Self-checking testbench for the instruction execution core
`timescale 1ns/1ns
`default_nettype none

module test_cie_exec_core;
  import cie_pkg::*;

  logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic [15:0] cyc0;
  int          miscompares = 0;
  int          nChecks = 0;

  cie_exec_core DUT (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  task automatic results();
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Request held until pready is sampled high; data and error taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(q, exp);
  endtask : rdc

  // Busy is polled a bounded number of times, never assumed to clear at a fixed edge
  task automatic exec(input logic [10:0] cmd);
    int n;
    wr(OFF_CMD, {21'h0, cmd});
    n = 0;
    do begin
      apb(1'h0, OFF_STATUS, 32'h0);
      n++;
    end while (q[STS_BUSY] !== 1'h0 && n < 8);
    chk({31'h0, q[STS_BUSY]}, 32'h0);
  endtask : exec

  task automatic run(input cie_op_e op, input logic ta, input logic [2:0] b,
                     input logic [9:0] ad, input logic [7:0] m, a, imm, input logic [5:0] f);
    logic [8:0] s, ds;
    logic [4:0] h;
    logic [7:0] r, ea, em;
    logic [5:0] ef;
    logic       cin, toA, sk;
    cin = (op == OP_ADC) & f[FLG_C];
    s = {1'h0, a} + {1'h0, m} + {8'h0, cin};
    h = {1'h0, a[3:0]} + {1'h0, m[3:0]} + {4'h0, cin};
    ds = {1'h0, a} + ((a[7:4] > BCD_MAX || f[FLG_C]) ? {1'h0, DAA_HIGH_ADJ} : 9'h0)
         + ((a[3:0] > BCD_MAX || f[FLG_AUX]) ? {1'h0, DAA_LOW_ADJ} : 9'h0);
    toA = (ta && op inside {OP_SWAP, OP_XOR, OP_ADC, OP_ADD, OP_AND, OP_OR, OP_CPL, OP_DEC,
           OP_INC, OP_RL, OP_RLC}) || op inside {OP_SKZA, OP_XORI, OP_MOVLD};
    sk = (op inside {OP_SKZ, OP_SKZA} && m == 8'h00) || (op == OP_SZBIT && !m[b]);
    ef = f;
    r = m;
    case (op)
      OP_SWAP:        r = {m[3:0], m[7:4]};
      OP_XOR:         r = a ^ m;
      OP_XORI:        r = a ^ imm;
      OP_ADC, OP_ADD: r = s[7:0];
      OP_AND:         r = a & m;
      OP_OR:          r = a | m;
      OP_CLR:         r = 8'h00;
      OP_CLRBIT:      r[b] = 1'h0;
      OP_CPL:         r = ~m;
      OP_DAA:         r = ds[7:0];
      OP_DEC:         r = m - 8'h01;
      OP_INC:         r = m + 8'h01;
      OP_MOVST:       r = a;
      OP_RL:          r = {m[6:0], m[7]};
      OP_RLC:         r = {m[6:0], f[FLG_C]};
      default:        ;
    endcase
    if (op inside {OP_ADC, OP_ADD}) begin
      ef[FLG_C] = s[8];
      ef[FLG_AUX] = h[4];
      ef[FLG_OVF] = (a[7] == m[7]) && (r[7] != a[7]);
      ef[FLG_SGN] = ef[FLG_OVF] ^ r[7];
    end
    if (op == OP_RLC) ef[FLG_C] = m[7];
    if (op == OP_DAA) ef[FLG_C] = f[FLG_C] | ds[8];
    if (op inside {OP_XOR, OP_XORI, OP_ADC, OP_ADD, OP_AND, OP_OR, OP_CPL, OP_DEC, OP_INC})
      ef[FLG_Z] = (r == 8'h00);
    em = toA ? m : r;
    ea = toA ? r : a;
    wr(OFF_DMADDR, {22'h0, ad});
    wr(OFF_DMDATA, {24'h0, m});
    wr(OFF_ACC, {24'h0, a});
    wr(OFF_FLAGS, {26'h0, f});
    wr(OFF_OPADDR, {22'h0, ad});
    wr(OFF_IMM, {24'h0, imm});
    apb(1'h0, OFF_CYCLES, 32'h0);
    cyc0 = q[15:0];
    exec({b, 2'h1, ta, op});
    rdc(OFF_ACC, {24'h0, ea});
    rdc(OFF_FLAGS, {26'h0, ef});
    rdc(OFF_DMDATA, {24'h0, em});
    rdc(OFF_STATUS, {30'h0, sk, 1'h0});
    rdc(OFF_CYCLES, {16'h0, cyc0 + 16'h1 + {15'h0, sk}});
    if (sk) begin
      exec({3'h0, 2'h1, 1'h0, OP_INC});
      rdc(OFF_DMDATA, {24'h0, em});
      rdc(OFF_FLAGS, {26'h0, ef});
      rdc(OFF_STATUS, 32'h4);
    end
  endtask : run

  initial begin
    arst_n = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    repeat (5) @(posedge clock);
    arst_n <= 1'h1;
    rdc(OFF_ACC, 32'h0);
    rdc(OFF_FLAGS, 32'h0);
    rdc(OFF_THLATCH, 32'h0);
    run(OP_SWAP, 1'h0, 3'h0, 10'h3C1, 8'h1E, 8'h00, 8'h00, 6'h2A);
    run(OP_SWAP, 1'h1, 3'h0, 10'h2C1, 8'h1E, 8'h77, 8'h00, 6'h15);
    run(OP_SKZ, 1'h0, 3'h0, 10'h101, 8'h00, 8'h33, 8'h00, 6'h15);
    run(OP_SKZ, 1'h0, 3'h0, 10'h102, 8'h80, 8'h33, 8'h00, 6'h2A);
    run(OP_SKZA, 1'h0, 3'h0, 10'h203, 8'h00, 8'h55, 8'h00, 6'h2A);
    run(OP_SKZA, 1'h0, 3'h0, 10'h204, 8'h01, 8'h55, 8'h00, 6'h15);
    run(OP_SZBIT, 1'h0, 3'h3, 10'h305, 8'hF7, 8'h00, 8'h00, 6'h15);
    run(OP_SZBIT, 1'h0, 3'h7, 10'h306, 8'h80, 8'h00, 8'h00, 6'h2A);
    run(OP_XOR, 1'h0, 3'h0, 10'h007, 8'hF0, 8'h3C, 8'h00, 6'h2A);
    run(OP_XOR, 1'h1, 3'h0, 10'h008, 8'h3C, 8'h3C, 8'h00, 6'h11);
    run(OP_XORI, 1'h0, 3'h0, 10'h009, 8'h12, 8'hA5, 8'hA5, 6'h2B);
    run(OP_ADC, 1'h1, 3'h0, 10'h3F0, 8'h00, 8'h7F, 8'h00, 6'h21);
    run(OP_ADC, 1'h0, 3'h0, 10'h2F0, 8'h0F, 8'h01, 8'h00, 6'h01);
    run(OP_ADD, 1'h1, 3'h0, 10'h1F0, 8'h01, 8'hFF, 8'h00, 6'h3F);
    run(OP_ADD, 1'h0, 3'h0, 10'h0F0, 8'h80, 8'h80, 8'h00, 6'h20);
    run(OP_AND, 1'h1, 3'h0, 10'h211, 8'hC3, 8'h0F, 8'h00, 6'h2C);
    run(OP_AND, 1'h0, 3'h0, 10'h212, 8'hC3, 8'h3C, 8'h00, 6'h01);
    run(OP_OR, 1'h1, 3'h0, 10'h313, 8'h00, 8'h00, 8'h00, 6'h01);
    run(OP_OR, 1'h0, 3'h0, 10'h314, 8'hC0, 8'h03, 8'h00, 6'h3F);
    run(OP_CLR, 1'h0, 3'h0, 10'h115, 8'hA5, 8'h00, 8'h00, 6'h1B);
    run(OP_CLRBIT, 1'h0, 3'h0, 10'h116, 8'hFF, 8'h00, 8'h00, 6'h24);
    run(OP_CPL, 1'h0, 3'h0, 10'h217, 8'hFF, 8'h11, 8'h00, 6'h01);
    run(OP_CPL, 1'h1, 3'h0, 10'h218, 8'h0F, 8'h11, 8'h00, 6'h04);
    run(OP_DAA, 1'h0, 3'h0, 10'h319, 8'h00, 8'h9A, 8'h00, 6'h2C);
    run(OP_DAA, 1'h0, 3'h0, 10'h31A, 8'h00, 8'h15, 8'h00, 6'h03);
    run(OP_DAA, 1'h0, 3'h0, 10'h31B, 8'h00, 8'hA0, 8'h00, 6'h00);
    run(OP_DEC, 1'h0, 3'h0, 10'h01C, 8'h00, 8'h22, 8'h00, 6'h04);
    run(OP_DEC, 1'h1, 3'h0, 10'h01D, 8'h01, 8'h22, 8'h00, 6'h00);
    run(OP_INC, 1'h0, 3'h0, 10'h11E, 8'hFF, 8'h22, 8'h00, 6'h00);
    run(OP_INC, 1'h1, 3'h0, 10'h11F, 8'h7F, 8'h22, 8'h00, 6'h04);
    run(OP_MOVLD, 1'h0, 3'h0, 10'h220, 8'h9C, 8'h01, 8'h00, 6'h3F);
    run(OP_MOVST, 1'h0, 3'h0, 10'h321, 8'h9C, 8'h6D, 8'h00, 6'h00);
    run(OP_RL, 1'h0, 3'h0, 10'h022, 8'h81, 8'h00, 8'h00, 6'h3F);
    run(OP_RL, 1'h1, 3'h0, 10'h023, 8'h40, 8'h00, 8'h00, 6'h00);
    run(OP_RLC, 1'h0, 3'h0, 10'h124, 8'h80, 8'h00, 8'h00, 6'h2E);
    run(OP_RLC, 1'h1, 3'h0, 10'h125, 8'h01, 8'h00, 8'h00, 6'h01);
    // Pointer at 0xFF so the incrementing forms must wrap the low byte
    for (int k = 0; k < 4; k++) begin
      wr(OFF_PMADDR, {20'h0, k[0] ? 4'hF : 4'h3, k >= 2 ? 8'h00 : 8'hFF});
      wr(OFF_PMDATA, {16'h0, 6'h30, k[1:0], 6'h10, k[1:0]});
      wr(OFF_TPLOW, 32'hFF);
      wr(OFF_TPHIGH, 32'h03);
      wr(OFF_OPADDR, 32'h155);
      wr(OFF_DMADDR, 32'h155);
      exec({3'h0, 3'h2, 5'h05 + {3'h0, k[1:0]}});
      rdc(OFF_DMDATA, {24'h0, 6'h10, k[1:0]});
      rdc(OFF_THLATCH, {24'h0, 6'h30, k[1:0]});
      rdc(OFF_TPLOW, k >= 2 ? 32'h00 : 32'hFF);
    end
    wr(OFF_DMADDR, 32'h0A5);
    wr(OFF_DMDATA, 32'h11);
    wr(OFF_DMADDR, 32'h2A5);
    wr(OFF_DMDATA, 32'h22);
    wr(OFF_OPADDR, 32'h2A5);
    exec({3'h0, 3'h2, OP_MOVLD});
    rdc(OFF_ACC, 32'h22);
    exec({3'h0, 3'h0, OP_MOVLD});
    rdc(OFF_ACC, 32'h11);
    apb(1'h0, 8'hFC, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(OFF_THLATCH, 32'h00);
    chk({31'h0, e}, 32'h0);
    rdc(OFF_THLATCH, 32'hC3);
    results();
  end

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    results();
  end

endmodule : test_cie_exec_core
`default_nettype wire
